// ---- hw/irq_flag_pkg.sv ----
package irq_flag_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFF_CTL_ONE = 8'h00;
    localparam logic [7:0] OFF_CTL_TWO = 8'h04;
    localparam logic [7:0] OFF_CTL_THREE = 8'h08;
    localparam logic [7:0] OFF_FLAGS_TWO = 8'h0C;
    localparam logic [7:0] OFF_ENABLE_TWO = 8'h10;
    localparam logic [7:0] OFF_TMR_CTL = 8'h14;
    localparam logic [7:0] OFF_TMR_CNT = 8'h18;
    // irq_control_one fields
    localparam int C1_GIE = 7;
    localparam int C1_TMR_EN = 5;
    localparam int C1_EXT_IRQ_ZERO_PIN_EN = 4;
    localparam int C1_PC_EN = 3;
    localparam int C1_TMR_FLAG = 2;
    localparam int C1_EXT_IRQ_ZERO_PIN_FLAG = 1;
    localparam int C1_PC_FLAG = 0;
    // irq_control_two fields, polarities for pins 0..3 at 3..6
    localparam int C2_POL_LO = 3;
    localparam int C2_TMR_PRIO = 2;
    localparam int C2_INT3_PRIO = 1;
    localparam int C2_PC_PRIO = 0;
    // irq_control_three fields, pins 1..3 enables and flags
    localparam int C3_INT2_PRIO = 7;
    localparam int C3_INT1_PRIO = 6;
    localparam int C3_EN_LO = 3;
    localparam int C3_FLAG_LO = 0;
    // peripheral_irq_flags_two fields
    localparam int F2_OSC = 7;
    localparam int F2_CMP2 = 6;
    localparam int F2_CMP1 = 5;
    localparam int F2_USB = 4;
    localparam int F2_BCL = 3;
    localparam int F2_LV = 2;
    // Timer control fields
    localparam int T_RUN = 0;
    localparam int T_WIDE = 1;
    // Reset values and roll-over points
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] TMR8_MAX = 8'hFF;
    localparam logic [15:0] TMR16_MAX = 16'hFFFF;
endpackage

// ---- hw/interrupt_flag_logic.sv ----
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Pin edge direction set by polarity bit
// - Valid pin edge sets its flag
// - Cleared enable blocks that pin's request
// - Pin wakes core if enabled before sleep
// - Branch after wake only with global enable
// - Pins one to three use priority bits
// - Pin zero is always high priority
// - Eight-bit timer wrap sets overflow flag
// - Sixteen-bit timer wrap sets overflow flag
// - Timer request gated, prioritised by bits
// - Port upper nibble change sets flag
// - Port change gated, prioritised by bits
// - Taking interrupt pushes return address
// - Taking interrupt shadows working/status/bank
// - Oscillator failure sets flag bit seven
// - Comparator input changes set bits six, five
// - Usb and bus collision set bits four, three
// - Low voltage sets flag bit two
module interrupt_flag_logic #(
    parameter int PC_W = 21,
    parameter int STACK_DEPTH = 8
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [3:0] ext_pin_i,
    input wire logic [3:0] port_pin_i,
    input wire logic [1:0] cmp_in_i,
    input wire logic osc_fail_i,
    input wire logic usb_irq_i,
    input wire logic bus_collision_i,
    input wire logic low_voltage_i,
    input wire logic sleeping_i,
    input wire logic irq_ack_i,
    input wire logic irq_return_i,
    input wire logic [PC_W-1:0] return_pc_i,
    input wire logic [7:0] working_i,
    input wire logic [7:0] status_i,
    input wire logic [7:0] bank_i,
    output logic irq_high_o,
    output logic irq_low_o,
    output logic wake_o,
    output logic branch_o,
    output logic [PC_W-1:0] stack_top_o,
    output logic [7:0] shadow_working_o,
    output logic [7:0] shadow_status_o,
    output logic [7:0] shadow_bank_o
);
    localparam int SP_W = $clog2(STACK_DEPTH + 1);
    localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

    logic rst_meta, rst_n; // Reset release synchroniser
    logic [3:0] ext_meta, ext_s, ext_d; // External pins
    logic [3:0] port_meta, port_s, port_d; // Watched port nibble
    logic [1:0] cmp_meta, cmp_s, cmp_d; // Comparator inputs
    logic global_irq_enable, tmr_en, pc_en, tmr_flag, pc_flag; // Control one
    logic [3:0] int_en, int_flag, pol, wake_en;
    logic tmr_prio, pc_prio; // Priority bits
    logic [2:0] int_prio; // Pins one..three
    logic [7:0] flags2, en2; // Second flag set and its enables
    logic t_run, t_wide;
    logic [15:0] t_cnt;
    logic sleep_d; // Previous sleep level, marks entry
    logic [PC_W-1:0] stack [STACK_DEPTH]; // Return address stack
    logic [SP_W-1:0] sp;
    logic wr, setup;
    logic [3:0] ext_edge;
    logic ovf8, ovf16, pc_change;
    logic [7:0] next_flags2_set;
    logic [31:0] next_rdata;
    logic mapped;

    // Offset match, shared by write and read decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    // Reset release through two flops, assertion stays asynchronous
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Pin synchronisers; edges compare the second stage with the third
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta <= 4'h0;
            ext_s <= 4'h0;
            ext_d <= 4'h0;
            port_meta <= 4'h0;
            port_s <= 4'h0;
            port_d <= 4'h0;
            cmp_meta <= 2'h0;
            cmp_s <= 2'h0;
            cmp_d <= 2'h0;
        end else begin
            ext_meta <= ext_pin_i;
            ext_s <= ext_meta;
            ext_d <= ext_s;
            port_meta <= port_pin_i;
            port_s <= port_meta;
            port_d <= port_s;
            cmp_meta <= cmp_in_i;
            cmp_s <= cmp_meta;
            cmp_d <= cmp_s;
        end
    end

    // Bus phases; zero wait states, so pready is constant high
    assign setup = psel_i & ~penable_i;
    assign wr = psel_i & penable_i & pwrite_i;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    // Edge qualified by polarity: one means rising, zero falling
    assign ext_edge = (pol & ext_s & ~ext_d) | (~pol & ~ext_s & ext_d);
    // Wrap detection in the selected timer width
    assign ovf8 = t_run & ~t_wide & (t_cnt[7:0] == irq_flag_pkg::TMR8_MAX);
    assign ovf16 = t_run & t_wide & (t_cnt == irq_flag_pkg::TMR16_MAX);
    assign pc_change = (port_s != port_d);

    // Hardware events for the second flag register
    always_comb begin
        next_flags2_set = 8'h00;
        next_flags2_set[irq_flag_pkg::F2_OSC] = osc_fail_i;
        next_flags2_set[irq_flag_pkg::F2_CMP2] = cmp_s[1] ^ cmp_d[1];
        next_flags2_set[irq_flag_pkg::F2_CMP1] = cmp_s[0] ^ cmp_d[0];
        next_flags2_set[irq_flag_pkg::F2_USB] = usb_irq_i;
        next_flags2_set[irq_flag_pkg::F2_BCL] = bus_collision_i;
        next_flags2_set[irq_flag_pkg::F2_LV] = low_voltage_i;
    end

    // Control one; a hardware set beats a same-cycle software clear
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            global_irq_enable <= 1'b0;
            tmr_en <= 1'b0;
            int_en[0] <= 1'b0;
            pc_en <= 1'b0;
            tmr_flag <= 1'b0;
            int_flag[0] <= 1'b0;
            pc_flag <= 1'b0;
        end else begin
            if (wr && hit(paddr_i, irq_flag_pkg::OFF_CTL_ONE)) begin
                global_irq_enable <= pwdata_i[irq_flag_pkg::C1_GIE];
                tmr_en <= pwdata_i[irq_flag_pkg::C1_TMR_EN];
                int_en[0] <= pwdata_i[irq_flag_pkg::C1_EXT_IRQ_ZERO_PIN_EN];
                pc_en <= pwdata_i[irq_flag_pkg::C1_PC_EN];
                tmr_flag <= pwdata_i[irq_flag_pkg::C1_TMR_FLAG] | ovf8 | ovf16;
                int_flag[0] <= pwdata_i[irq_flag_pkg::C1_EXT_IRQ_ZERO_PIN_FLAG]
                    | ext_edge[0];
                pc_flag <= pwdata_i[irq_flag_pkg::C1_PC_FLAG] | pc_change;
            end else begin
                // Flags only ever set here; software alone clears
                tmr_flag <= tmr_flag | ovf8 | ovf16;
                int_flag[0] <= int_flag[0] | ext_edge[0];
                pc_flag <= pc_flag | pc_change;
            end
        end
    end

    // Control two: polarities and priorities
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pol <= 4'h0;
            tmr_prio <= 1'b0;
            int_prio[2] <= 1'b0;
            pc_prio <= 1'b0;
        end else if (wr && hit(paddr_i, irq_flag_pkg::OFF_CTL_TWO)) begin
            pol <= pwdata_i[irq_flag_pkg::C2_POL_LO +: 4];
            tmr_prio <= pwdata_i[irq_flag_pkg::C2_TMR_PRIO];
            int_prio[2] <= pwdata_i[irq_flag_pkg::C2_INT3_PRIO];
            pc_prio <= pwdata_i[irq_flag_pkg::C2_PC_PRIO];
        end
    end

    // Control three: pins one..three enables and flags, pins one and two priorities
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            int_prio[1:0] <= 2'h0;
            int_en[3:1] <= 3'h0;
            int_flag[3:1] <= 3'h0;
        end else if (wr && hit(paddr_i, irq_flag_pkg::OFF_CTL_THREE)) begin
            int_prio[1] <= pwdata_i[irq_flag_pkg::C3_INT2_PRIO];
            int_prio[0] <= pwdata_i[irq_flag_pkg::C3_INT1_PRIO];
            int_en[3:1] <= pwdata_i[irq_flag_pkg::C3_EN_LO +: 3];
            int_flag[3:1] <= pwdata_i[irq_flag_pkg::C3_FLAG_LO +: 3]
                | ext_edge[3:1];
        end else begin
            int_flag[3:1] <= int_flag[3:1] | ext_edge[3:1];
        end
    end

    // Second flag register and its enables, all bits read/write
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            flags2 <= irq_flag_pkg::RST_BYTE;
            en2 <= irq_flag_pkg::RST_BYTE;
        end else begin
            if (wr && hit(paddr_i, irq_flag_pkg::OFF_FLAGS_TWO)) begin
                flags2 <= pwdata_i[7:0] | next_flags2_set;
            end else begin
                flags2 <= flags2 | next_flags2_set;
            end
            if (wr && hit(paddr_i, irq_flag_pkg::OFF_ENABLE_TWO)) begin
                en2 <= pwdata_i[7:0];
            end
        end
    end

    // Timer zero; a software load wins over the running count
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            t_run <= 1'b0;
            t_wide <= 1'b0; // Eight-bit mode by default
            t_cnt <= irq_flag_pkg::RST_WORD;
        end else begin
            if (wr && hit(paddr_i, irq_flag_pkg::OFF_TMR_CTL)) begin
                t_run <= pwdata_i[irq_flag_pkg::T_RUN];
                t_wide <= pwdata_i[irq_flag_pkg::T_WIDE];
            end
            if (wr && hit(paddr_i, irq_flag_pkg::OFF_TMR_CNT)) begin
                t_cnt <= pwdata_i[15:0];
            end else if (t_run && t_wide) begin
                t_cnt <= t_cnt + 16'h0001;
            end else if (t_run) begin
                // High byte holds while only the low byte counts
                t_cnt[7:0] <= t_cnt[7:0] + 8'h01;
            end
        end
    end

    // Read mux; unmapped offsets read zero and report an error
    always_comb begin
        next_rdata = 32'h0000_0000;
        mapped = 1'b1;
        if (hit(paddr_i, irq_flag_pkg::OFF_CTL_ONE)) begin
            next_rdata[7:0] = {global_irq_enable, 1'b0, tmr_en, int_en[0], pc_en,
                tmr_flag, int_flag[0], pc_flag};
        end else if (hit(paddr_i, irq_flag_pkg::OFF_CTL_TWO)) begin
            next_rdata[7:0] = {1'b0, pol, tmr_prio, int_prio[2], pc_prio};
        end else if (hit(paddr_i, irq_flag_pkg::OFF_CTL_THREE)) begin
            next_rdata[7:0] = {int_prio[1], int_prio[0], int_en[3:1],
                int_flag[3:1]};
        end else if (hit(paddr_i, irq_flag_pkg::OFF_FLAGS_TWO)) begin
            next_rdata[7:0] = flags2;
        end else if (hit(paddr_i, irq_flag_pkg::OFF_ENABLE_TWO)) begin
            next_rdata[7:0] = en2;
        end else if (hit(paddr_i, irq_flag_pkg::OFF_TMR_CTL)) begin
            next_rdata[1:0] = {t_wide, t_run};
        end else if (hit(paddr_i, irq_flag_pkg::OFF_TMR_CNT)) begin
            next_rdata[15:0] = t_cnt;
        end else begin
            mapped = 1'b0;
        end
    end

    // Read data captured in the setup cycle, held for the access
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup && !pwrite_i) begin
            prdata_o <= next_rdata;
        end
    end

    // Requests split by priority; pin zero has no priority bit
    always_comb begin
        irq_high_o = (int_flag[0] & int_en[0])
            | (|(int_flag[3:1] & int_en[3:1] & int_prio))
            | (tmr_flag & tmr_en & tmr_prio)
            | (pc_flag & pc_en & pc_prio);
        irq_low_o = (|(int_flag[3:1] & int_en[3:1] & ~int_prio))
            | (tmr_flag & tmr_en & ~tmr_prio)
            | (pc_flag & pc_en & ~pc_prio)
            | (|(flags2 & en2));
    end

    // Enables are frozen at sleep entry; later enables do not wake
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            sleep_d <= 1'b0;
            wake_en <= 4'h0;
        end else begin
            sleep_d <= sleeping_i;
            if (sleeping_i && !sleep_d) begin
                wake_en <= int_en;
            end
        end
    end

    assign wake_o = sleeping_i & sleep_d & (|(int_flag & wake_en));
    assign branch_o = global_irq_enable & (irq_high_o | irq_low_o);

    // Return stack; a push on a full stack is dropped, not wrapped
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            sp <= '0;
            stack_top_o <= '0;
        end else if (irq_ack_i && sp != SP_FULL) begin
            stack[sp[$clog2(STACK_DEPTH)-1:0]] <= return_pc_i;
            stack_top_o <= return_pc_i;
            sp <= sp + 1'b1;
        end else if (irq_return_i && !irq_ack_i && sp != '0) begin
            sp <= sp - 1'b1;
            stack_top_o <= (sp > SP_W'(1))
                ? stack[sp[$clog2(STACK_DEPTH)-1:0] - 2'd2] : '0;
        end
    end

    // Fast-return shadow copy on every accepted interrupt
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            shadow_working_o <= 8'h00;
            shadow_status_o <= 8'h00;
            shadow_bank_o <= 8'h00;
        end else if (irq_ack_i) begin
            shadow_working_o <= working_i;
            shadow_status_o <= status_i;
            shadow_bank_o <= bank_i;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    sequence s_rise0;
        pol[0] && ext_s[0] && !ext_d[0];
    endsequence
    sequence s_wrap8;
        ovf8 && !(wr && paddr_i == irq_flag_pkg::OFF_TMR_CNT);
    endsequence

    a_ext_rise_flag: assert property (s_rise0 |=> int_flag[0])
        else $error("rising edge did not set pin zero flag");
    a_fall_ignored: assert property (
        pol[0] && !ext_s[0] && ext_d[0] && !int_flag[0] && !wr
        |=> !int_flag[0])
        else $error("falling edge set flag under rising polarity");
    a_enable_gates: assert property (
        int_en == 4'h0 && !tmr_en && !pc_en && en2 == 8'h00
        |-> !irq_high_o && !irq_low_o)
        else $error("request raised with all enables clear");
    a_ext_irq_zero_pin_high: assert property (
        int_flag[0] && int_en[0] |-> irq_high_o)
        else $error("pin zero request not high priority");
    a_int1_low: assert property (
        int_flag[1] && int_en[1] && !int_prio[0] |-> irq_low_o)
        else $error("pin one low priority request missing");
    a_wake_frozen: assert property (
        (int_flag & wake_en) == 4'h0 |-> !wake_o)
        else $error("wake without enable held at sleep entry");
    a_branch_gie: assert property (!global_irq_enable |-> !branch_o)
        else $error("branch without global enable");
    a_tmr8_wrap: assert property (
        s_wrap8 |=> tmr_flag && t_cnt[7:0] == 8'h00)
        else $error("eight-bit wrap missed");
    a_tmr16_wrap: assert property (
        ovf16 && !wr |=> tmr_flag && t_cnt == 16'h0000)
        else $error("sixteen-bit wrap missed");
    a_port_change: assert property (pc_change |=> pc_flag)
        else $error("port change did not set flag");
    a_flag_sticky: assert property (
        int_flag[0] && !psel_i |=> int_flag[0] [*2])
        else $error("flag dropped without software write");
    a_ctx_push: assert property (
        irq_ack_i && sp != SP_FULL |=> stack_top_o == $past(return_pc_i)
        && shadow_working_o == $past(working_i))
        else $error("context not saved on acknowledge");
    a_low_voltage: assert property (
        low_voltage_i |=> flags2[2])
        else $error("low voltage flag not set");
endmodule
`default_nettype wire

// ---- dv/core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Processor core stand-in: takes each new request once, after a delay
module core_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic branch_i,
    input wire logic ret_i,
    input wire logic [3:0] delay_i,
    input wire logic [20:0] pc_i,
    input wire logic [7:0] ctx_i,
    output logic irq_ack_o,
    output logic irq_return_o,
    output logic [20:0] return_pc_o,
    output logic [7:0] working_o,
    output logic [7:0] status_o,
    output logic [7:0] bank_o
);
    logic prev; // Branch level one cycle ago
    logic pend; // Request seen, acknowledge outstanding
    logic [3:0] cnt; // Cycles waited so far
    // Acknowledge once per rising request, so the stack is not flooded
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev <= 1'b0;
            pend <= 1'b0;
            cnt <= 4'h0;
            irq_ack_o <= 1'b0;
        end else begin
            prev <= branch_i;
            irq_ack_o <= 1'b0;
            if (branch_i && !prev && !pend) begin
                pend <= 1'b1;
                cnt <= 4'h0;
            end else if (pend) begin
                // Slow or prompt answer, as the bench commands
                if (cnt >= delay_i) begin
                    irq_ack_o <= 1'b1;
                    pend <= 1'b0;
                end
                cnt <= cnt + 4'h1;
            end
        end
    end
    // Return pulse one cycle after ret, even in the same cycle as a take
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_return_o <= 1'b0;
        end else begin
            irq_return_o <= ret_i;
        end
    end
    // Context is only meaningful during the take; inverted otherwise
    assign return_pc_o = irq_ack_o ? pc_i : ~pc_i;
    assign working_o = irq_ack_o ? ctx_i : ~ctx_i;
    assign status_o = irq_ack_o ? {ctx_i[3:0], ctx_i[7:4]} : ~ctx_i;
    assign bank_o = irq_ack_o ? (ctx_i ^ 8'hA5) : ~ctx_i;
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module tb_top;
    logic mclk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [7:0] paddr_i, working_i, status_i, bank_i, ctx, c1, c2, c3;
    logic [31:0] pwdata_i, prdata_o, q;
    logic [3:0] ext_pin_i, port_pin_i, delay;
    logic [1:0] cmp_in_i;
    logic osc_fail_i, usb_irq_i, bus_collision_i, low_voltage_i, sleeping_i;
    logic irq_ack_i, irq_return_i, ret, irq_high_o, irq_low_o, wake_o;
    logic branch_o, err, f;
    logic [20:0] return_pc_i, stack_top_o, pc;
    logic [7:0] shadow_working_o, shadow_status_o, shadow_bank_o;
    int fails, comparisons, cycles;
    // Device under test, all inputs driven
    interrupt_flag_logic interrupt_flag_logic_i (
        .mclk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ext_pin_i,
        .port_pin_i, .cmp_in_i, .osc_fail_i, .usb_irq_i, .bus_collision_i,
        .low_voltage_i, .sleeping_i, .irq_ack_i, .irq_return_i,
        .return_pc_i, .working_i, .status_i, .bank_i, .irq_high_o,
        .irq_low_o, .wake_o, .branch_o, .stack_top_o, .shadow_working_o,
        .shadow_status_o, .shadow_bank_o);
    // Core stand-in on the far side
    core_model core_model_i (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .branch_i(branch_o),
        .ret_i(ret), .delay_i(delay), .pc_i(pc), .ctx_i(ctx),
        .irq_ack_o(irq_ack_i), .irq_return_o(irq_return_i),
        .return_pc_o(return_pc_i), .working_o(working_i),
        .status_o(status_i), .bank_o(bank_i));
    // 100 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // Hang guard, well above the expected run length
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end
    task automatic conclude();
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // Short names for the register offsets
    localparam logic [7:0] A1 = irq_flag_pkg::OFF_CTL_ONE,
        A2 = irq_flag_pkg::OFF_CTL_TWO, A3 = irq_flag_pkg::OFF_CTL_THREE,
        AF = irq_flag_pkg::OFF_FLAGS_TWO, AE = irq_flag_pkg::OFF_ENABLE_TWO,
        AT = irq_flag_pkg::OFF_TMR_CTL, AC = irq_flag_pkg::OFF_TMR_CNT;
    // One APB transfer; held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // Extra edge so later checks see what the write has updated
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h00000000, r);
    endtask
    // Pin zero flag lives in control one, pins one..three in control three
    task automatic pin_flag(input int p);
        rd(p == 0 ? A1 : A3, q);
        f = (p == 0) ? q[1] : q[p - 1];
    endtask
    // Main sequence
    initial begin
        {rst_n_i, psel_i, penable_i, pwrite_i, sleeping_i, ret} = '0;
        {osc_fail_i, usb_irq_i, bus_collision_i, low_voltage_i} = '0;
        {paddr_i, pwdata_i, ext_pin_i, port_pin_i, cmp_in_i} = '0;
        {delay, pc, ctx, fails, comparisons, cycles} = '0;
        cyc(16);
        rst_n_i <= 1'b1;
        cyc(5);
        // Second flag register: reset, read/write, width, unmapped
        rd(AF, q);
        `CHK("flags_two reset", 8'h00, q);
        wr(AF, 32'hFFFFFFA5);
        rd(AF, q);
        `CHK("flags_two rw", 8'hA5, q);
        wr(AF, 32'h0);
        rd(8'hFC, q);
        `CHK("unmapped err", 1'b1, err);
        `CHK("stack reset", 21'h0, stack_top_o);
        // Peripheral event sources, one at a time, low priority
        for (int i = 0; i < 6; i++) begin
            wr(AE, 32'(1 << (7 - i)));
            case (i)
                0: osc_fail_i <= 1'b1;
                1: cmp_in_i[1] <= ~cmp_in_i[1];
                2: cmp_in_i[0] <= ~cmp_in_i[0];
                3: usb_irq_i <= 1'b1;
                4: bus_collision_i <= 1'b1;
                default: low_voltage_i <= 1'b1;
            endcase
            cyc(1);
            {osc_fail_i, usb_irq_i, bus_collision_i, low_voltage_i} <= '0;
            cyc(6);
            rd(AF, q);
            `CHK("flags_two set", 1 << (7 - i), q);
            `CHK("periph req", 1'b1, irq_low_o);
            wr(AF, 32'h0);
        end
        wr(AE, 32'h0);
        // External pins, both polarities, pins one..three priorities follow polarity, pin zero always high
        for (int p = 0; p < 4; p++) begin
            for (int pol = 0; pol < 2; pol++) begin
                c1 = (p == 0) ? 8'h10 : 8'h00;
                c2 = 8'(pol << (3 + p)) | ((p == 3) ? 8'(pol << 1) : 8'h00);
                c3 = (p == 0) ? 8'h00 : 8'(1 << (2 + p));
                c3 = c3 | ((p == 1 || p == 2) ? 8'(pol << (5 + p)) : 8'h00);
                wr(A2, 32'(c2));
                wr(A1, 32'(c1));
                wr(A3, 32'(c3));
                ext_pin_i[p] <= 1'(pol);
                cyc(6);
                wr(A1, 32'(c1));
                wr(A3, 32'(c3));
                ext_pin_i[p] <= !1'(pol);
                cyc(6);
                pin_flag(p);
                `CHK("wrong edge", 1'b0, f);
                ext_pin_i[p] <= 1'(pol);
                cyc(6);
                pin_flag(p);
                `CHK("valid edge", 1'b1, f);
                `CHK("irq high", (p == 0) || pol, irq_high_o);
                `CHK("irq low", (p != 0) && !pol, irq_low_o);
                // Drop the enable but keep the flag written back as one
                wr(A1, (p == 0) ? 32'h2 : 32'h0);
                wr(A3, (p == 0) ? 32'h0 : 32'((c3 & 8'hC0) | 8'(1 << (p - 1))));
                `CHK("disabled", 2'b00, {irq_high_o, irq_low_o});
                pin_flag(p);
                `CHK("sticky flag", 1'b1, f);
                wr(A1, 32'h0);
                wr(A3, 32'h0);
            end
        end
        // Timer, 8-bit wrap then 16-bit wrap past a low-byte roll
        wr(AT, 32'h0);
        wr(AC, 32'h00FD);
        wr(A2, 32'h04);
        wr(A1, 32'h20);
        rd(A1, q);
        `CHK("tmr idle", 1'b0, q[2]);
        wr(AT, 32'h1);
        cyc(6);
        rd(A1, q);
        `CHK("tmr8 wrap", 1'b1, q[2]);
        `CHK("tmr high", 1'b1, irq_high_o);
        wr(A2, 32'h0);
        `CHK("tmr low", 1'b1, irq_low_o);
        wr(A1, 32'h04);
        `CHK("tmr gated", 1'b0, irq_low_o);
        wr(AT, 32'h0);
        wr(A1, 32'h0);
        wr(AC, 32'h00FE);
        wr(AT, 32'h3);
        cyc(6);
        rd(A1, q);
        `CHK("tmr16 no wrap", 1'b0, q[2]);
        wr(AC, 32'hFFFE);
        cyc(6);
        rd(A1, q);
        `CHK("tmr16 wrap", 1'b1, q[2]);
        wr(AT, 32'h0);
        // Port change on each watched pin, alternating priority
        for (int p = 0; p < 4; p++) begin
            wr(A1, 32'h08);
            wr(A2, 32'(p % 2));
            port_pin_i[p] <= 1'b1;
            cyc(6);
            rd(A1, q);
            `CHK("port change", 1'b1, q[0]);
            `CHK("port prio", {p % 2 == 1, p % 2 == 0}, {irq_high_o, irq_low_o});
            wr(A1, 32'h01);
            `CHK("port gated", 2'b00, {irq_high_o, irq_low_o});
        end
        // Wake: only pins enabled before sleep entry count
        wr(A2, 32'h0);
        wr(A1, 32'h10);
        sleeping_i <= 1'b1;
        cyc(3);
        wr(A3, 32'h08);
        ext_pin_i[1] <= 1'b0;
        cyc(6);
        `CHK("late enable wake", 1'b0, wake_o);
        ext_pin_i[0] <= 1'b0;
        cyc(6);
        `CHK("wake", 1'b1, wake_o);
        `CHK("no branch", 1'b0, branch_o);
        pc = 21'h1ABCDE;
        ctx = 8'h3C;
        wr(A1, 32'h92);
        `CHK("branch", 1'b1, branch_o);
        cyc(10);
        `CHK("stack push", pc, stack_top_o);
        `CHK("shadow w", ctx, shadow_working_o);
        `CHK("shadow s", {ctx[3:0], ctx[7:4]}, shadow_status_o);
        `CHK("shadow b", ctx ^ 8'hA5, shadow_bank_o);
        sleeping_i <= 1'b0;
        wr(A1, 32'h80);
        wr(A3, 32'h08);
        // Slow take of a second interrupt, then a return pop
        delay = 4'h9;
        pc = 21'h0F0F0F;
        ctx = 8'hC6;
        ext_pin_i[1] <= 1'b1;
        cyc(6);
        ext_pin_i[1] <= 1'b0;
        cyc(6);
        `CHK("slow take", 21'h1ABCDE, stack_top_o);
        cyc(15);
        `CHK("second push", pc, stack_top_o);
        `CHK("shadow w2", ctx, shadow_working_o);
        ret <= 1'b1;
        cyc(1);
        ret <= 1'b0;
        cyc(4);
        `CHK("stack pop", 21'h1ABCDE, stack_top_o);
        conclude();
    end
endmodule
`default_nettype wire
